// ==== shared/excvec_defs.svh ====
// Constants of the exception vector and reset unit
`ifndef EXCVEC_DEFS_SVH
`define EXCVEC_DEFS_SVH
`define RESET_BASE 32'hBFC0_0000
`define BEV0_BASE 32'h8000_0000
`define BEV1_BASE 32'hBFC0_0200
`define OFS_TLB 32'h0000_0000
`define OFS_XTLB 32'h0000_0080
`define OFS_COMMON 32'h0000_0180
`define RANDOM_TOP 5'h1F
`define SOFT_MIN_CYC 5'h10
`define HOLD_SAT 5'h1F
`define MODE_KERNEL 2'h0
`define N_INSTR_EXC 18
`define DIV_MASK3 3'h7
`define DIV_MASK2 3'h3
`define ADR_STATUS 8'h00
`define ADR_CONFIG 8'h04
`define ADR_ERR_LO 8'h08
`define ADR_ERR_HI 8'h0C
`define ADR_RANDOM 8'h10
`define ADR_VEC_LO 8'h14
`define ADR_VEC_HI 8'h18
`define ADR_CAUSE 8'h1C
`define ST_EXL_POS 0
`define ST_ERL_POS 1
`define ST_PRIV_POS 2
`define ST_BEV_POS 4
`define ST_TS_POS 5
`define ST_SR_POS 6
`define ST_RP_POS 7
`define CF_EC_POS 0
`define CF_EP_POS 3
`define CF_BE_POS 7
`define STATUS_RST 8'h12
`define CONFIG_RST 8'h80
`endif

// ==== shared/excvec_pkg.sv ====
// Types of the exception vector and reset unit
package excvec_pkg;
   typedef enum logic [4:0] {
      EXC_COLD, EXC_SOFT, EXC_NMI,
      EXC_IADE, EXC_ITLBM, EXC_ITLBI, EXC_IBUS,
      EXC_SYS, EXC_BP, EXC_CPU, EXC_RI, EXC_TRAP, EXC_OV, EXC_FPE,
      EXC_DADE, EXC_DTLBM, EXC_DTLBI, EXC_MOD, EXC_WATCH, EXC_DBUS,
      EXC_INT, EXC_NONE
   } exc_type;

   typedef struct packed {
      logic reduced_power_bit;
      logic soft_reset_flag;
      logic tlb_shutdown_bit;
      logic bootstrap_vector_bit;
      logic [1:0] privilege_mode_field;
      logic error_level_bit;
      logic exception_level_bit;
   } status_type;

   typedef struct packed {
      logic big_endian_bit;
      logic [3:0] writeback_pattern_field;
      logic [2:0] system_clock_ratio_field;
   } config_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } bus_req_type;
endpackage

// ==== hw/cpu_exception_vector_reset_unit.sv ====
// Exception priority, vector generation and reset handling of the core
`include "excvec_defs.svh"

// Functional notes
// - Mode field applies unless exception/error level set
// - Taking any exception other than resets and NMI sets exception level
// - Exception return clears exception level
// - Resets and NMI vector to reset address
// - Other vectors are bootstrap base plus offset
// - Offsets 0, 0x80 TLB refill, else 0x180
// - Resets and NMI force bootstrap vector bit
// - Nested TLB miss uses common offset
// - Report only highest priority exception
// - Fixed priority from cold reset to interrupt
// - Cold reset on pin release, never masked
// - Cold reset clears shutdown, flag, power, pattern
// - Cold reset sets error, bootstrap, big endian
// - Cold reset loads replacement index 31
// - Cold reset copies divide pins to ratio
// - Reset vector works with caches uninitialised
// - Soft reset needs over 16 cycles asserted
// - Soft reset resets state machines, refetches
// - Soft reset saves PC if error level clear
// - Soft reset sets flag, error, bootstrap bits
// - Soft reset leaves cache and memory undefined
module cpu_exception_vector_reset_unit #(
   parameter int DIV_PINS = 3
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic power_on_reset_input_b,
   input wire logic soft_reset_input_b,
   input wire logic [2:0] clock_divide_pins,
   input wire excvec_pkg::bus_req_type bus_req,
   output logic [31:0] rdata_ff,
   input wire logic nmi_req,
   input wire logic instr_valid,
   input wire logic [`N_INSTR_EXC-1:0] exc_pending,
   input wire logic xtlb_space,
   input wire logic eret_req,
   input wire logic [63:0] cur_pc,
   output logic redirect_ff,
   output logic [63:0] vector_ff,
   output excvec_pkg::exc_type exc_code_ff,
   output logic [1:0] run_mode_ff,
   output logic kernel_mode_ff,
   output logic sm_reset_ff,
   output logic mem_undef_ff
);
   import excvec_pkg::*;

   localparam logic [2:0] DIV_MASK = (DIV_PINS >= 3) ? `DIV_MASK3 : `DIV_MASK2;

   function automatic logic [63:0] sext32(input logic [31:0] a);
      return {{32{a[31]}}, a};
   endfunction

   // Lowest pending index wins; resets and NMI sit above all of them
   function automatic exc_type pick(
      input logic c,
      input logic s,
      input logic n,
      input logic v,
      input logic [`N_INSTR_EXC-1:0] p
   );
      exc_type r;
      r = EXC_NONE;
      if (v) begin
         for (int i = `N_INSTR_EXC - 1; i >= 0; i--) begin
            if (p[i]) begin
               r = exc_type'(5'(i + 3));
            end
         end
      end
      if (n && v) begin
         r = EXC_NONE;
         r = EXC_NMI;
      end
      if (s) begin
         r = EXC_SOFT;
      end
      if (c) begin
         r = EXC_COLD;
      end
      return r;
   endfunction

   logic [2:0] cold_sy_ff;
   logic [2:0] soft_sy_ff;
   logic [2:0] div_s1_ff;
   logic [2:0] div_s2_ff;
   logic [2:0] div_s3_ff;
   logic [2:0] div_ff;
   logic cold_asrt_ff;
   logic soft_asrt_ff;
   logic [4:0] hold_cnt_ff;
   logic nmi_pend_ff;
   status_type status_ff;
   config_type config_ff;
   logic [4:0] random_ff;
   logic [63:0] erepc_ff;

   status_type nxt_status;
   config_type nxt_config;
   logic [4:0] nxt_random;
   logic [63:0] nxt_erepc;
   logic [4:0] nxt_hold_cnt;

   // Pin filters: a level counts once stages two and three agree
   wire cold_agree = cold_sy_ff[1] == cold_sy_ff[2];
   wire soft_agree = soft_sy_ff[1] == soft_sy_ff[2];
   wire [2:0] div_agree = ~(div_s2_ff ^ div_s3_ff);

   wire cold_rel = cold_asrt_ff && cold_agree && !cold_sy_ff[2];
   wire soft_rel = soft_asrt_ff && soft_agree && !soft_sy_ff[2];

   wire cold_ev = cold_rel;
   wire soft_ev = soft_rel && !cold_asrt_ff && !cold_ev
                  && (hold_cnt_ff >= `SOFT_MIN_CYC); // Count lags by one

   wire wr_status = bus_req.wr && bus_req.addr == `ADR_STATUS;
   wire wr_config = bus_req.wr && bus_req.addr == `ADR_CONFIG;
   wire wr_err_lo = bus_req.wr && bus_req.addr == `ADR_ERR_LO;
   wire wr_err_hi = bus_req.wr && bus_req.addr == `ADR_ERR_HI;
   wire wr_random = bus_req.wr && bus_req.addr == `ADR_RANDOM;

   wire exc_type sel = pick(cold_ev, soft_ev, nmi_pend_ff || nmi_req,
                            instr_valid, exc_pending);
   wire take = sel != EXC_NONE;
   wire is_rst = sel == EXC_COLD || sel == EXC_SOFT || sel == EXC_NMI;
   wire is_nmi = sel == EXC_NMI;
   wire is_tlbm = sel == EXC_ITLBM || sel == EXC_DTLBM;

   wire [31:0] vec_base = status_ff.bootstrap_vector_bit ?
                          `BEV1_BASE : `BEV0_BASE;
   // Dedicated refill offsets only for a first-level miss
   wire [31:0] vec_ofs = (is_tlbm && !status_ff.exception_level_bit) ?
                         (xtlb_space ? `OFS_XTLB : `OFS_TLB) :
                         `OFS_COMMON;
   // Reset vector lies in uncached unmapped space, so no cache or TLB
   // state is needed to fetch from it
   wire [31:0] vec32 = is_rst ? `RESET_BASE
                              : vec_base + vec_ofs;
   wire [63:0] nxt_vector = sext32(vec32);

   wire [1:0] nxt_mode = (nxt_status.exception_level_bit
                          || nxt_status.error_level_bit) ?
                         `MODE_KERNEL :
                         nxt_status.privilege_mode_field;

   wire [31:0] rd_mux =
      (bus_req.addr == `ADR_STATUS) ? {24'h0, status_ff} :
      (bus_req.addr == `ADR_CONFIG) ? {24'h0, config_ff} :
      (bus_req.addr == `ADR_ERR_LO) ? erepc_ff[31:0] :
      (bus_req.addr == `ADR_ERR_HI) ? erepc_ff[63:32] :
      (bus_req.addr == `ADR_RANDOM) ? {27'h0, random_ff} :
      (bus_req.addr == `ADR_VEC_LO) ? vector_ff[31:0] :
      (bus_req.addr == `ADR_VEC_HI) ? vector_ff[63:32] :
      (bus_req.addr == `ADR_CAUSE) ? {27'h0, exc_code_ff} :
      32'h0;

   always_comb begin
      nxt_hold_cnt = 5'h0;
      if (soft_asrt_ff && !cold_asrt_ff) begin
         nxt_hold_cnt = (hold_cnt_ff == `HOLD_SAT) ? hold_cnt_ff
                        : hold_cnt_ff + 5'h1;
      end
   end

   // Hardware events are applied after bus writes so they win
   always_comb begin
      nxt_status = status_ff;
      if (wr_status) begin
         nxt_status = status_type'(bus_req.wdata[7:0]);
      end
      if (eret_req) begin
         nxt_status.exception_level_bit = 1'b0;
      end
      if (cold_ev) begin
         nxt_status.tlb_shutdown_bit = 1'b0;
         nxt_status.soft_reset_flag = 1'b0;
         nxt_status.reduced_power_bit = 1'b0;
         nxt_status.error_level_bit = 1'b1;
         nxt_status.bootstrap_vector_bit = 1'b1;
      end else if (soft_ev || is_nmi) begin
         nxt_status.tlb_shutdown_bit = 1'b0;
         nxt_status.reduced_power_bit = soft_ev ?
            1'b0 : nxt_status.reduced_power_bit;
         nxt_status.error_level_bit = 1'b1;
         nxt_status.soft_reset_flag = 1'b1;
         nxt_status.bootstrap_vector_bit = 1'b1;
      end else if (take) begin
         nxt_status.exception_level_bit = 1'b1;
      end
   end

   always_comb begin
      nxt_config = config_ff;
      nxt_random = random_ff;
      if (wr_config) begin
         nxt_config = config_type'(bus_req.wdata[7:0]);
      end
      if (wr_random) begin
         nxt_random = bus_req.wdata[4:0];
      end
      if (cold_ev) begin
         nxt_config.writeback_pattern_field = 4'h0;
         nxt_config.big_endian_bit = 1'b1;
         nxt_config.system_clock_ratio_field = div_ff & DIV_MASK;
         nxt_random = `RANDOM_TOP;
      end
   end

   always_comb begin
      nxt_erepc = erepc_ff;
      if (wr_err_lo) begin
         nxt_erepc[31:0] = bus_req.wdata;
      end
      if (wr_err_hi) begin
         nxt_erepc[63:32] = bus_req.wdata;
      end
      if ((soft_ev && !status_ff.error_level_bit) || is_nmi) begin
         nxt_erepc = cur_pc;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cold_sy_ff <= 3'h0;
         soft_sy_ff <= 3'h0;
         div_s1_ff <= 3'h0;
         div_s2_ff <= 3'h0;
         div_s3_ff <= 3'h0;
      end else begin
         cold_sy_ff <= {cold_sy_ff[1:0], !power_on_reset_input_b};
         soft_sy_ff <= {soft_sy_ff[1:0], !soft_reset_input_b};
         div_s1_ff <= clock_divide_pins;
         div_s2_ff <= div_s1_ff;
         div_s3_ff <= div_s2_ff;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cold_asrt_ff <= 1'b0;
         soft_asrt_ff <= 1'b0;
         div_ff <= 3'h0;
         hold_cnt_ff <= 5'h0;
      end else begin
         cold_asrt_ff <= cold_agree ? cold_sy_ff[2] : cold_asrt_ff;
         soft_asrt_ff <= soft_agree ? soft_sy_ff[2] : soft_asrt_ff;
         div_ff <= (div_agree & div_s3_ff) | (~div_agree & div_ff);
         hold_cnt_ff <= nxt_hold_cnt;
      end
   end

   // A pending NMI waits for an instruction boundary; new request wins
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         nmi_pend_ff <= 1'b0;
      end else begin
         nmi_pend_ff <= nmi_req || (nmi_pend_ff && !is_nmi);
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         status_ff <= status_type'(`STATUS_RST);
         config_ff <= config_type'(`CONFIG_RST);
         random_ff <= `RANDOM_TOP;
         erepc_ff <= 64'h0;
      end else begin
         status_ff <= nxt_status;
         config_ff <= nxt_config;
         random_ff <= nxt_random;
         erepc_ff <= nxt_erepc;
      end
   end

   // Soft reset may cut cache and bus transfers short, so memory state
   // is flagged as undefined rather than drained
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         redirect_ff <= 1'b0;
         vector_ff <= 64'h0;
         exc_code_ff <= EXC_NONE;
         run_mode_ff <= `MODE_KERNEL;
         kernel_mode_ff <= 1'b1;
         sm_reset_ff <= 1'b0;
         mem_undef_ff <= 1'b0;
         rdata_ff <= 32'h0;
      end else begin
         redirect_ff <= take;
         vector_ff <= take ? nxt_vector : vector_ff;
         exc_code_ff <= take ? sel : exc_code_ff;
         run_mode_ff <= nxt_mode;
         kernel_mode_ff <= nxt_mode == `MODE_KERNEL;
         sm_reset_ff <= cold_ev || soft_ev;
         mem_undef_ff <= soft_ev;
         rdata_ff <= bus_req.rd ? rd_mux : 32'h0;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   sequence s_cold_release;
      cold_asrt_ff ##1 !cold_asrt_ff;
   endsequence

   sequence s_soft_short;
      (soft_asrt_ff && hold_cnt_ff < `SOFT_MIN_CYC) ##1 !soft_asrt_ff;
   endsequence

   a_kernel_mode_map: assert property (
      (status_ff.exception_level_bit || status_ff.error_level_bit)
      |-> kernel_mode_ff && run_mode_ff == `MODE_KERNEL)
      else $error("kernel mode not shown while level bit set");

   a_user_mode_map: assert property (
      !(status_ff.exception_level_bit || status_ff.error_level_bit)
      |-> run_mode_ff == status_ff.privilege_mode_field)
      else $error("run mode differs from mode field");

   a_exl_on_take: assert property (
      take && !is_rst |=> status_ff.exception_level_bit && kernel_mode_ff)
      else $error("exception level not set on exception");

   a_eret_clears_exl: assert property (
      eret_req && !take && !wr_status |=> !status_ff.exception_level_bit)
      else $error("exception return left level set");

   a_reset_vector_addr: assert property (
      take && is_rst |=> redirect_ff && vector_ff == sext32(`RESET_BASE))
      else $error("reset vector wrong");

   a_bev_forced_set: assert property (
      take && is_rst |=> status_ff.bootstrap_vector_bit)
      else $error("bootstrap bit not forced");

   a_nested_tlb_ofs: assert property (
      take && is_tlbm && status_ff.exception_level_bit
      |=> vector_ff[8:0] == 9'(`OFS_COMMON))
      else $error("nested TLB miss not on common offset");

   a_vector_sext: assert property (
      redirect_ff |-> vector_ff[63:32] == {32{vector_ff[31]}})
      else $error("vector not sign-extended");

   a_fetch_priority: assert property (
      instr_valid && exc_pending[0] && !cold_ev && !soft_ev
      && !nmi_pend_ff && !nmi_req |=> exc_code_ff == EXC_IADE)
      else $error("fetch address error lost priority");

   a_cold_unmasked: assert property (
      s_cold_release |-> sm_reset_ff && redirect_ff
      && exc_code_ff == EXC_COLD)
      else $error("cold reset release not taken");

   a_cold_clears: assert property (
      s_cold_release |-> !status_ff.tlb_shutdown_bit
      && !status_ff.soft_reset_flag && !status_ff.reduced_power_bit
      && config_ff.writeback_pattern_field == 4'h0)
      else $error("cold reset did not clear bits");

   a_cold_sets: assert property (
      s_cold_release |-> status_ff.error_level_bit
      && status_ff.bootstrap_vector_bit && config_ff.big_endian_bit)
      else $error("cold reset did not set bits");

   a_cold_random: assert property (
      s_cold_release |-> random_ff == `RANDOM_TOP)
      else $error("replacement index not at top");

   a_cold_ratio: assert property (
      s_cold_release |-> config_ff.system_clock_ratio_field
      == ($past(div_ff) & DIV_MASK))
      else $error("clock ratio not taken from pins");

   a_soft_short_pulse: assert property (
      s_soft_short |-> !sm_reset_ff)
      else $error("short soft reset pulse was taken");

   a_soft_saves_pc: assert property (
      soft_ev && !status_ff.error_level_bit |=> erepc_ff == $past(cur_pc))
      else $error("error return address not saved");

   a_soft_status: assert property (
      soft_ev |=> status_ff.soft_reset_flag && status_ff.error_level_bit
      && status_ff.bootstrap_vector_bit && !status_ff.tlb_shutdown_bit
      && !status_ff.reduced_power_bit && sm_reset_ff && mem_undef_ff)
      else $error("soft reset status wrong");
endmodule

// ==== test/reset_source_model.sv ====
// External reset source that drives the cold and soft reset pins on the master clock
module reset_source_model (
   input wire logic mclk,
   output logic power_on_reset_input_b,
   output logic soft_reset_input_b
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      power_on_reset_input_b = 1'b1;
      soft_reset_input_b = 1'b1;
   end

   // Assert, hold, then release; the unit only acts on the release
   task automatic cold_pulse(input int n);
      @(posedge mclk);
      power_on_reset_input_b <= 1'b0;
      repeat (n) @(posedge mclk);
      power_on_reset_input_b <= 1'b1;
   endtask

   // Cold pin stays released throughout; n above 16 for a real soft reset
   task automatic soft_pulse(input int n);
      @(posedge mclk);
      soft_reset_input_b <= 1'b0;
      repeat (n) @(posedge mclk);
      soft_reset_input_b <= 1'b1;
   endtask
endmodule

// ==== test/cpu_exception_vector_reset_unit_bench.sv ====
// Self-checking bench of the exception vector and reset unit
`include "excvec_defs.svh"
`define CHK(got, exp) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
   end \
end

module cpu_exception_vector_reset_unit_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import excvec_pkg::*;

   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   wire logic power_on_reset_input_b;
   wire logic soft_reset_input_b;
   logic [2:0] clock_divide_pins;
   bus_req_type bus_req;
   logic [31:0] rdata_ff;
   logic nmi_req;
   logic instr_valid;
   logic [17:0] exc_pending;
   logic xtlb_space;
   logic eret_req;
   logic [63:0] cur_pc;
   logic redirect_ff;
   logic [63:0] vector_ff;
   exc_type exc_code_ff;
   logic [1:0] run_mode_ff;
   logic kernel_mode_ff;
   logic sm_reset_ff;
   logic mem_undef_ff;
   int error_cnt = 0;
   int checks_done = 0;
   bit hit;
   logic [7:0] st_t [4] = '{8'h01, 8'h10, 8'h10, 8'h00};
   int ix_t [4] = '{12, 1, 4, 12};
   logic xt_t [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
   logic [63:0] v_t [4] = '{64'hFFFF_FFFF_8000_0180, 64'hFFFF_FFFF_BFC0_0280,
      64'hFFFF_FFFF_BFC0_0380, 64'hFFFF_FFFF_8000_0080};

   always #2.5 mclk = ~mclk;

   cpu_exception_vector_reset_unit #(.DIV_PINS(3)) cpu_exception_vector_reset_unit_i (
      .mclk, .rst_b, .power_on_reset_input_b, .soft_reset_input_b, .clock_divide_pins,
      .bus_req, .rdata_ff, .nmi_req, .instr_valid, .exc_pending, .xtlb_space, .eret_req,
      .cur_pc, .redirect_ff, .vector_ff, .exc_code_ff, .run_mode_ff, .kernel_mode_ff,
      .sm_reset_ff, .mem_undef_ff);

   reset_source_model reset_source_model_i (
      .mclk, .power_on_reset_input_b, .soft_reset_input_b);

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      bus_req.wr <= 1'b0;
   endtask

   // Read data live only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      #1 `CHK(rdata_ff, exp)
   endtask

   task automatic take(input logic [17:0] p, input logic x, input logic [63:0] v,
         input exc_type c);
      @(posedge mclk);
      instr_valid <= 1'b1;
      exc_pending <= p;
      xtlb_space <= x;
      @(posedge mclk);
      instr_valid <= 1'b0;
      exc_pending <= '0;
      #1 `CHK(redirect_ff, 1'b1)
      `CHK(vector_ff, v)
      `CHK(exc_code_ff, c)
   endtask

   task automatic eret;
      @(posedge mclk);
      eret_req <= 1'b1;
      @(posedge mclk);
      eret_req <= 1'b0;
   endtask

   // Bounded watch for the state machine reset pulse
   task automatic wait_ev(output bit h);
      h = 1'b0;
      for (int n = 0; n < 24 && !h; n++) begin
         @(posedge mclk);
         #1 h = (sm_reset_ff === 1'b1);
      end
   endtask

   task automatic complete_run;
      $display("errors=%0d checks=%0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      #100us;
      error_cnt++;
      complete_run();
   end

   initial begin
      bus_req = '0;
      nmi_req = 1'b0;
      instr_valid = 1'b0;
      exc_pending = '0;
      xtlb_space = 1'b0;
      eret_req = 1'b0;
      cur_pc = 64'h1234_5678_9ABC_DEF0;
      clock_divide_pins = 3'h5;
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      rd(`ADR_STATUS, 32'h12);
      rd(`ADR_CONFIG, 32'h80);
      rd(8'h20, 32'h0);
      // Dirty every field a cold reset must restore
      wr(`ADR_STATUS, 32'hE0);
      wr(`ADR_CONFIG, 32'h78);
      wr(`ADR_RANDOM, 32'h3);
      wr(`ADR_CAUSE, 32'h5);
      rd(`ADR_CAUSE, 32'h15);
      reset_source_model_i.cold_pulse(5);
      wait_ev(hit);
      `CHK(hit, 1'b1)
      `CHK(redirect_ff, 1'b1)
      `CHK(vector_ff, 64'hFFFF_FFFF_BFC0_0000)
      `CHK(exc_code_ff, EXC_COLD)
      rd(`ADR_STATUS, 32'h12);
      rd(`ADR_CONFIG, 32'h85);
      rd(`ADR_RANDOM, 32'h1F);
      rd(`ADR_VEC_LO, 32'hBFC0_0000);
      rd(`ADR_VEC_HI, 32'hFFFF_FFFF);
      // Every lower-priority bit stays set so only the top one may win
      for (int i = 0; i < 18; i++) begin
         wr(`ADR_STATUS, 32'h08);
         rd(`ADR_STATUS, 32'h08);
         `CHK(run_mode_ff, 2'h2)
         `CHK(kernel_mode_ff, 1'b0)
         take(18'h3FFFF << i, 1'b0, (i == 1 || i == 12) ? 64'hFFFF_FFFF_8000_0000 :
            64'hFFFF_FFFF_8000_0180, exc_type'(i + 3));
         rd(`ADR_STATUS, 32'h09);
         `CHK(kernel_mode_ff, 1'b1)
         eret();
         rd(`ADR_STATUS, 32'h08);
      end
      for (int k = 0; k < 4; k++) begin
         wr(`ADR_STATUS, {24'h0, st_t[k]});
         take(18'h1 << ix_t[k], xt_t[k], v_t[k], exc_type'(ix_t[k] + 3));
         eret();
      end
      wr(`ADR_STATUS, 32'h0);
      @(posedge mclk);
      nmi_req <= 1'b1;
      @(posedge mclk);
      nmi_req <= 1'b0;
      take(18'h1, 1'b0, 64'hFFFF_FFFF_BFC0_0000, EXC_NMI);
      rd(`ADR_STATUS, 32'h52);
      wr(`ADR_STATUS, 32'hA0);
      cur_pc <= 64'hFEDC_BA98_7654_3210;
      reset_source_model_i.soft_pulse(16);
      wait_ev(hit);
      `CHK(hit, 1'b0)
      reset_source_model_i.soft_pulse(17);
      wait_ev(hit);
      `CHK(hit, 1'b1)
      `CHK(mem_undef_ff, 1'b1)
      `CHK(redirect_ff, 1'b1)
      `CHK(vector_ff, 64'hFFFF_FFFF_BFC0_0000)
      `CHK(exc_code_ff, EXC_SOFT)
      rd(`ADR_STATUS, 32'h52);
      rd(`ADR_CONFIG, 32'h85);
      rd(`ADR_ERR_LO, 32'h7654_3210);
      rd(`ADR_ERR_HI, 32'hFEDC_BA98);
      // Error level already set, so the saved address must survive
      @(posedge mclk);
      cur_pc <= 64'h0;
      reset_source_model_i.soft_pulse(20);
      wait_ev(hit);
      `CHK(hit, 1'b1)
      rd(`ADR_ERR_HI, 32'hFEDC_BA98);
      complete_run();
   end
endmodule
